// file: src/timer16_defs.svh
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH

`define IO_ADDR_W 4
`define IO_DATA_W 8

// I/O locations
`define A_CTRL_A 4'h0
`define A_CTRL_B 4'h1
`define A_CTRL_C 4'h2
`define A_CNT_L 4'h3
`define A_CNT_H 4'h4
`define A_CMPA_L 4'h5
`define A_CMPA_H 4'h6
`define A_CMPB_L 4'h7
`define A_CMPB_H 4'h8
`define A_CMPC_L 4'h9
`define A_CMPC_H 4'ha
`define A_CAP_L 4'hb
`define A_CAP_H 4'hc
`define A_FLAGS 4'hd

// Fields
`define WM_LO_MSB 1
`define WM_LO_LSB 0
`define WM_HI_MSB 4
`define WM_HI_LSB 3
`define CS_MSB 2
`define CS_LSB 0
`define FOC_A_BIT 7
`define FOC_B_BIT 6
`define FOC_C_BIT 5
`define OVF_BIT 0

`define REG8_RESET 8'h00
`define REG16_RESET 16'h0000

// Counter landmarks
`define CNT_BOTTOM 16'h0000
`define CNT_MAX 16'hffff
`define CNT_ONE 16'h0001
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV_B 3'h2
`define CS_DIV_C 3'h3
`define CS_DIV_D 3'h4
`define CS_DIV_E 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Wave modes
`define WM_NORMAL 4'h0
`define WM_PC8 4'h1
`define WM_PC9 4'h2
`define WM_PC10 4'h3
`define WM_CTC_A 4'h4
`define WM_FAST8 4'h5
`define WM_FAST9 4'h6
`define WM_FAST10 4'h7
`define WM_PFC_CAP 4'h8
`define WM_PFC_A 4'h9
`define WM_PC_CAP 4'ha
`define WM_PC_A 4'hb
`define WM_CTC_CAP 4'hc
`define WM_FAST_CAP 4'he
`define WM_FAST_A 4'hf

`endif

// file: src/timer16_pkg.sv
`include "timer16_defs.svh"
package timer16_pkg;

  typedef struct packed {
    logic [`IO_ADDR_W-1:0] addr;
    logic wr_en;
    logic rd_en;
    logic [`IO_DATA_W-1:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic bottom;
    logic max;
    logic top;
  } count_status_t;

  typedef enum logic [2:0] {
    TOP_MAX, TOP_8, TOP_9, TOP_10, TOP_CMPA, TOP_CAP
  } top_src_t;

  typedef enum logic [2:0] {
    SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_PHASE, SEQ_PFC
  } seq_t;

  typedef struct packed {
    top_src_t top_src;
    seq_t seq;
    logic pwm;
  } mode_info_t;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

endpackage : timer16_pkg

// file: src/timer_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module timer_tick_gen #(
  parameter int DIV_B = 8,
  parameter int DIV_C = 64,
  parameter int DIV_D = 256,
  parameter int DIV_E = 1024,
  parameter int PRE_W = 10
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] clock_select_field,
  input wire logic ext_clock_pin,
  output logic timer_tick
);

  logic [PRE_W-1:0] pre_reg;
  logic [2:0] ext_sync_reg;
  logic pin_level_reg;
  logic pin_agree;
  logic ext_rise;
  logic ext_fall;

  function automatic logic div_hit(input logic [PRE_W-1:0] cnt,
                                   input int div);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'(div - 1);
    div_hit = (cnt & mask) == '0;
  endfunction : div_hit

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  // Pin synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin};
    end
  end

  assign pin_agree = ext_sync_reg[1] == ext_sync_reg[2];

  // Accepted pin level; a change counts once two late stages agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level_reg <= 1'b0;
    end else if (pin_agree) begin
      pin_level_reg <= ext_sync_reg[2];
    end
  end

  assign ext_rise = pin_agree && ext_sync_reg[2] && !pin_level_reg;
  assign ext_fall = pin_agree && !ext_sync_reg[2] && pin_level_reg;

  always_comb begin
    case (clock_select_field)
      `CS_STOP: timer_tick = 1'b0;
      `CS_DIV1: timer_tick = 1'b1;
      `CS_DIV_B: timer_tick = div_hit(pre_reg, DIV_B);
      `CS_DIV_C: timer_tick = div_hit(pre_reg, DIV_C);
      `CS_DIV_D: timer_tick = div_hit(pre_reg, DIV_D);
      `CS_DIV_E: timer_tick = div_hit(pre_reg, DIV_E);
      `CS_EXT_FALL: timer_tick = ext_fall;
      `CS_EXT_RISE: timer_tick = ext_rise;
      default: timer_tick = 1'b0;
    endcase
  end

endmodule : timer_tick_gen
`default_nettype wire

// file: src/timer16_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
module timer16_core #(
  parameter int DIV_B = 8,
  parameter int DIV_C = 64,
  parameter int DIV_D = 256,
  parameter int DIV_E = 1024
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire timer16_pkg::io_req_t io_req,
  output logic [7:0] rd_data,
  input wire logic ext_clock_pin,
  input wire logic capture_event,
  output timer16_pkg::count_status_t count_status,
  output logic overflow_flag,
  output logic [2:0] compare_match,
  output logic [2:0] force_compare,
  output logic pwm_a_allowed
);
  import timer16_pkg::*;

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] temp_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] capture_value_reg;
  logic [15:0] cmp_buf_reg [3];
  logic [15:0] cmp_act_reg [3];
  dir_t dir_reg;
  logic [3:0] wave_mode_field;
  mode_info_t mode;
  logic [15:0] top_value;
  logic timer_tick;
  logic at_top;
  logic at_bottom;
  logic cnt_wr;
  logic cap_wr;
  logic cap_ok;
  logic [2:0] cmp_lo_wr;
  logic [2:0] cmp_hi_rd;
  logic [2:0] cmp_lo_rd;
  logic hi_wr;
  logic ovf_event;
  logic buf_update;
  logic [15:0] wr_word;

  function automatic mode_info_t decode_mode(input logic [3:0] wm);
    case (wm)
      `WM_NORMAL: decode_mode = '{TOP_MAX, SEQ_NORMAL, 1'b0};
      `WM_PC8: decode_mode = '{TOP_8, SEQ_PHASE, 1'b1};
      `WM_PC9: decode_mode = '{TOP_9, SEQ_PHASE, 1'b1};
      `WM_PC10: decode_mode = '{TOP_10, SEQ_PHASE, 1'b1};
      `WM_CTC_A: decode_mode = '{TOP_CMPA, SEQ_CTC, 1'b0};
      `WM_FAST8: decode_mode = '{TOP_8, SEQ_FAST, 1'b1};
      `WM_FAST9: decode_mode = '{TOP_9, SEQ_FAST, 1'b1};
      `WM_FAST10: decode_mode = '{TOP_10, SEQ_FAST, 1'b1};
      `WM_PFC_CAP: decode_mode = '{TOP_CAP, SEQ_PFC, 1'b1};
      `WM_PFC_A: decode_mode = '{TOP_CMPA, SEQ_PFC, 1'b1};
      `WM_PC_CAP: decode_mode = '{TOP_CAP, SEQ_PHASE, 1'b1};
      `WM_PC_A: decode_mode = '{TOP_CMPA, SEQ_PHASE, 1'b1};
      `WM_CTC_CAP: decode_mode = '{TOP_CAP, SEQ_CTC, 1'b0};
      `WM_FAST_CAP: decode_mode = '{TOP_CAP, SEQ_FAST, 1'b1};
      `WM_FAST_A: decode_mode = '{TOP_CMPA, SEQ_FAST, 1'b1};
      default: decode_mode = '{TOP_MAX, SEQ_NORMAL, 1'b0};
    endcase
  endfunction : decode_mode

  timer_tick_gen #(
    .DIV_B(DIV_B),
    .DIV_C(DIV_C),
    .DIV_D(DIV_D),
    .DIV_E(DIV_E)
  ) u_tick (
    .mclk(mclk),
    .reset_n(reset_n),
    .clock_select_field(ctrl_b_reg[`CS_MSB:`CS_LSB]),
    .ext_clock_pin(ext_clock_pin),
    .timer_tick(timer_tick)
  );

  // Mode bit 3 and 2 live in control B, bits 1 and 0 in control A
  assign wave_mode_field = {ctrl_b_reg[`WM_HI_MSB:`WM_HI_LSB],
                            ctrl_a_reg[`WM_LO_MSB:`WM_LO_LSB]};
  assign mode = decode_mode(wave_mode_field);

  always_comb begin
    case (mode.top_src)
      TOP_8: top_value = `TOP_8BIT;
      TOP_9: top_value = `TOP_9BIT;
      TOP_10: top_value = `TOP_10BIT;
      TOP_CMPA: top_value = cmp_act_reg[0];
      TOP_CAP: top_value = capture_value_reg;
      default: top_value = `CNT_MAX;
    endcase
  end

  assign at_top = counter_value_reg == top_value;
  assign at_bottom = counter_value_reg == `CNT_BOTTOM;
  assign count_status = '{bottom: at_bottom,
                          max: counter_value_reg == `CNT_MAX,
                          top: at_top};
  assign pwm_a_allowed = !(mode.pwm && mode.top_src == TOP_CMPA);

  // Access decode
  assign wr_word = {temp_reg, io_req.wdata};
  assign cnt_wr = io_req.wr_en && io_req.addr == `A_CNT_L;
  assign cap_ok = mode.top_src == TOP_CAP;
  assign cap_wr = io_req.wr_en && io_req.addr == `A_CAP_L && cap_ok;
  assign hi_wr = io_req.wr_en && (io_req.addr == `A_CNT_H ||
                 io_req.addr == `A_CMPA_H || io_req.addr == `A_CMPB_H ||
                 io_req.addr == `A_CMPC_H || io_req.addr == `A_CAP_H);
  always_comb begin
    cmp_lo_wr = {io_req.addr == `A_CMPC_L, io_req.addr == `A_CMPB_L,
                 io_req.addr == `A_CMPA_L} & {3{io_req.wr_en}};
    cmp_lo_rd = {io_req.addr == `A_CMPC_L, io_req.addr == `A_CMPB_L,
                 io_req.addr == `A_CMPA_L} & {3{io_req.rd_en}};
    cmp_hi_rd = {io_req.addr == `A_CMPC_H, io_req.addr == `A_CMPB_H,
                 io_req.addr == `A_CMPA_H} & {3{io_req.rd_en}};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_reg <= `REG8_RESET;
      ctrl_b_reg <= `REG8_RESET;
    end else if (io_req.wr_en) begin
      if (io_req.addr == `A_CTRL_A) ctrl_a_reg <= io_req.wdata;
      if (io_req.addr == `A_CTRL_B) ctrl_b_reg <= io_req.wdata;
    end
  end

  // Shared high-byte latch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      temp_reg <= `REG8_RESET;
    end else if (hi_wr) begin
      temp_reg <= io_req.wdata;
    end else if (io_req.rd_en && io_req.addr == `A_CNT_L) begin
      temp_reg <= counter_value_reg[15:8];
    end else if (io_req.rd_en && io_req.addr == `A_CAP_L) begin
      temp_reg <= capture_value_reg[15:8];
    end
  end

  // Counting
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      counter_value_reg <= `REG16_RESET;
      dir_reg <= DIR_UP;
    end else if (cnt_wr) begin
      counter_value_reg <= wr_word;
    end else if (timer_tick) begin
      case (mode.seq)
        SEQ_CTC, SEQ_FAST: begin
          counter_value_reg <= at_top ? `CNT_BOTTOM
                               : counter_value_reg + `CNT_ONE;
        end
        SEQ_PHASE, SEQ_PFC: begin
          case (dir_reg)
            DIR_UP: begin
              if (at_top) begin
                dir_reg <= DIR_DOWN;
                counter_value_reg <= counter_value_reg - `CNT_ONE;
              end else begin
                counter_value_reg <= counter_value_reg + `CNT_ONE;
              end
            end
            DIR_DOWN: begin
              if (at_bottom) begin
                dir_reg <= DIR_UP;
                counter_value_reg <= counter_value_reg + `CNT_ONE;
              end else begin
                counter_value_reg <= counter_value_reg - `CNT_ONE;
              end
            end
            default: dir_reg <= DIR_UP;
          endcase
        end
        default: counter_value_reg <= counter_value_reg + `CNT_ONE;
      endcase
    end
  end

  always_comb begin
    case (mode.seq)
      SEQ_FAST: ovf_event = timer_tick && at_top;
      SEQ_PHASE, SEQ_PFC: ovf_event = timer_tick && at_bottom &&
                                      dir_reg == DIR_DOWN;
      default: ovf_event = timer_tick && count_status.max;
    endcase
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event && !cnt_wr) begin
      overflow_flag <= 1'b1;
    end else if (io_req.wr_en && io_req.addr == `A_FLAGS &&
                 io_req.wdata[`OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      capture_value_reg <= `REG16_RESET;
    end else if (cap_wr) begin
      capture_value_reg <= wr_word;
    end else if (capture_event && !cap_ok) begin
      capture_value_reg <= counter_value_reg;
    end
  end

  // In PWM modes the active compare follows the buffer at the mode's update point; otherwise a write loads both at once
  always_comb begin
    case (mode.seq)
      SEQ_FAST: buf_update = timer_tick && at_top;
      SEQ_PHASE: buf_update = timer_tick && at_top && dir_reg == DIR_UP;
      SEQ_PFC: buf_update = timer_tick && at_bottom;
      default: buf_update = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 3; i++) begin
        cmp_buf_reg[i] <= `REG16_RESET;
        cmp_act_reg[i] <= `REG16_RESET;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cmp_lo_wr[i]) cmp_buf_reg[i] <= wr_word;
        if (!mode.pwm && cmp_lo_wr[i]) begin
          cmp_act_reg[i] <= wr_word;
        end else if (mode.pwm && buf_update) begin
          cmp_act_reg[i] <= cmp_buf_reg[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      compare_match <= 3'h0;
      force_compare <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        compare_match[i] <= timer_tick &&
                            counter_value_reg == cmp_act_reg[i];
      end
      force_compare <= (io_req.wr_en && io_req.addr == `A_CTRL_C &&
                        !mode.pwm) ? {io_req.wdata[`FOC_C_BIT],
                                      io_req.wdata[`FOC_B_BIT],
                                      io_req.wdata[`FOC_A_BIT]}
                                   : 3'h0;
    end
  end

  // Registered read port
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= `REG8_RESET;
    end else if (io_req.rd_en) begin
      case (io_req.addr)
        `A_CTRL_A: rd_data <= ctrl_a_reg;
        `A_CTRL_B: rd_data <= ctrl_b_reg;
        `A_CNT_L: rd_data <= counter_value_reg[7:0];
        `A_CNT_H, `A_CAP_H: rd_data <= temp_reg;
        `A_CMPA_L, `A_CMPB_L, `A_CMPC_L:
          rd_data <= cmp_buf_reg[cmp_lo_rd[2] ? 2 : cmp_lo_rd[1]][7:0];
        `A_CMPA_H, `A_CMPB_H, `A_CMPC_H:
          rd_data <= cmp_buf_reg[cmp_hi_rd[2] ? 2 : cmp_hi_rd[1]][15:8];
        `A_CAP_L: rd_data <= capture_value_reg[7:0];
        `A_FLAGS: rd_data <= {7'h00, overflow_flag};
        default: rd_data <= `REG8_RESET;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence fast_wrap_s;
    mode.seq == SEQ_FAST && timer_tick && at_top && !cnt_wr;
  endsequence

  sequence low_read_cnt_s;
    io_req.rd_en && io_req.addr == `A_CNT_L;
  endsequence

  chk_write_priority: assert property (
    cnt_wr |=> counter_value_reg == {$past(temp_reg), $past(io_req.wdata)})
    else $error("counter write lost to counting");
  chk_low_read_latch: assert property (
    low_read_cnt_s |=> temp_reg == $past(counter_value_reg[15:8]))
    else $error("low read did not latch high byte");
  chk_high_read_latch: assert property (
    low_read_cnt_s ##2 (io_req.rd_en && io_req.addr == `A_CNT_H)
    |=> rd_data == $past(counter_value_reg[15:8], 3))
    else $error("high read not from latch");
  chk_stop_hold: assert property (
    ctrl_b_reg[`CS_MSB:`CS_LSB] == `CS_STOP && !cnt_wr
    |=> $stable(counter_value_reg))
    else $error("stopped counter moved");
  chk_fast_wrap: assert property (
    fast_wrap_s |=> counter_value_reg == `CNT_BOTTOM && overflow_flag)
    else $error("fast mode wrap or overflow wrong");
  chk_cap_guard: assert property (
    io_req.wr_en && io_req.addr == `A_CAP_L && !cap_ok && !capture_event
    |=> $stable(capture_value_reg))
    else $error("capture written while not TOP");
  chk_cmp_high_read: assert property (
    cmp_hi_rd[0] |=> rd_data == $past(cmp_buf_reg[0][15:8]))
    else $error("compare high read went through latch");
  chk_latch_hold: assert property (
    !hi_wr && !(io_req.rd_en && (io_req.addr == `A_CNT_L ||
    io_req.addr == `A_CAP_L)) |=> $stable(temp_reg))
    else $error("latch changed without access");
  chk_ovf_sticky: assert property (
    overflow_flag && !(io_req.wr_en && io_req.addr == `A_FLAGS)
    |=> overflow_flag)
    else $error("overflow flag dropped");
  chk_pwm_a_off: assert property (
    wave_mode_field == `WM_PFC_A || wave_mode_field == `WM_PC_A ||
    wave_mode_field == `WM_FAST_A |-> !pwm_a_allowed)
    else $error("channel A PWM allowed while TOP");
  chk_cmp_buffered: assert property (
    mode.pwm && cmp_lo_wr[0] && !buf_update |=> $stable(cmp_act_reg[0]))
    else $error("compare A bypassed its buffer in PWM");

endmodule : timer16_core
`default_nettype wire

// file: verification/cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire logic mclk,
  input wire logic [7:0] rd_data,
  output var timer16_pkg::io_req_t io_req
);
  import timer16_pkg::*;
  // Extra idle cycles before each access
  int slow = 0;
  initial io_req = '0;
  // One byte access; pairs are not kept together and may be interleaved with other traffic
  task automatic access(input logic [3:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    repeat (slow + 1) @(posedge mclk);
    #1;
    io_req.addr = a;
    io_req.wr_en = w;
    io_req.rd_en = !w;
    io_req.wdata = d;
    @(posedge mclk);
    #1;
    q = rd_data;
    io_req.wr_en = 1'b0;
    io_req.rd_en = 1'b0;
    // Released lines do not keep the last value
    io_req.wdata = ~d;
    io_req.addr = ~a;
  endtask : access
endmodule : cpu_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import timer16_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  io_req_t io_req;
  logic [7:0] rd_data, q;
  count_status_t st;
  logic overflow_flag, pwm_a_allowed;
  logic [2:0] force_compare, seen;
  int n_errors = 0, n_compared = 0, cycles = 0, ref_cnt = 0, ref_latch = 0;
  int ref_cap = 0, ref_ca = 0, ref_cb = 0, mode, i, k;
  int ref_cmp[3] = '{0, 0, 0};
  logic [31:0] lfsr = 32'h1072;
  logic [15:0] v;
  int modes[14] = '{1, 2, 3, 5, 6, 7, 4, 8, 9, 10, 11, 12, 14, 15};
  logic ext_pin = 1'b0;
  logic cap_evt = 1'b0;

  always #12.5 mclk = ~mclk;

  cpu_model u_cpu (.mclk(mclk), .rd_data(rd_data), .io_req(io_req));

  timer16_core #(.DIV_B(2), .DIV_C(4), .DIV_D(8), .DIV_E(16)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .io_req(io_req), .rd_data(rd_data),
    .ext_clock_pin(ext_pin), .capture_event(cap_evt), .count_status(st),
    .overflow_flag(overflow_flag), .compare_match(),
    .force_compare(force_compare), .pwm_a_allowed(pwm_a_allowed));

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      summarize();
    end
  end

  function automatic logic [15:0] rnd16();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction : rnd16

  task automatic put(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_cpu.access(a, 1'b1, d, r);
    mode = {ref_cb[4:3], ref_ca[1:0]};
    case (a)
      `A_CTRL_A: ref_ca = d;
      `A_CTRL_B: ref_cb = d;
      `A_CNT_H, `A_CMPA_H, `A_CMPB_H, `A_CMPC_H, `A_CAP_H: ref_latch = d;
      `A_CNT_L: ref_cnt = {ref_latch[7:0], d};
      `A_CMPA_L, `A_CMPB_L, `A_CMPC_L:
        ref_cmp[(a - 5) / 2] = {ref_latch[7:0], d};
      `A_CAP_L: if (mode inside {8, 10, 12, 14})
        ref_cap = {ref_latch[7:0], d};
      default: ;
    endcase
  endtask : put

  task automatic w16(input logic [3:0] lo, input logic [15:0] d);
    put(lo + 4'h1, d[15:8]);
    put(lo, d[7:0]);
  endtask : w16

  task automatic get(input logic [3:0] a, input string nm);
    logic [7:0] r;
    int e;
    u_cpu.access(a, 1'b0, 8'h00, r);
    case (a)
      `A_CTRL_A: e = ref_ca;
      `A_CTRL_B: e = ref_cb;
      `A_CNT_L: begin e = ref_cnt; ref_latch = ref_cnt >> 8; end
      `A_CAP_L: begin e = ref_cap; ref_latch = ref_cap >> 8; end
      `A_CNT_H, `A_CAP_H: e = ref_latch;
      `A_CMPA_L, `A_CMPB_L, `A_CMPC_L: e = ref_cmp[(a - 5) / 2];
      `A_CMPA_H, `A_CMPB_H, `A_CMPC_H: e = ref_cmp[(a - 6) / 2] >> 8;
      default: e = 0;
    endcase
    `CHK(nm, e[7:0], r)
  endtask : get

  // Slow square pulses on the count pin, then time to settle
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge mclk);
      #1;
      ext_pin = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      ext_pin = 1'b0;
    end
    repeat (6) @(posedge mclk);
    #1;
  endtask : pulses

  task automatic set_mode(input int m, input logic [2:0] cs);
    put(`A_CTRL_A, {6'h00, m[1:0]});
    put(`A_CTRL_B, {3'h0, m[3:2], cs});
  endtask : set_mode

  initial begin
    repeat (8) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    `CHK("bottom after reset", 1'b1, st.bottom)
    for (i = 0; i < 4; i++) begin
      v = rnd16();
      u_cpu.slow = i;
      w16(`A_CNT_L, v);
      repeat (5) @(posedge mclk);
      get(`A_CNT_L, "cnt low");
      get(`A_CNT_H, "cnt high");
    end
    u_cpu.slow = 0;
    put(`A_CNT_H, ~v[15:8]);
    for (i = 0; i < 3; i++) put(4'(5 + 2 * i), 8'(rnd16() >> 8));
    get(`A_CNT_L, "cnt low");
    for (i = 0; i < 3; i++) begin
      get(4'(5 + 2 * i), "cmp low");
      get(4'(6 + 2 * i), "cmp high");
    end
    get(`A_CAP_H, "shared latch");
    for (k = 0; k < 2; k++) begin
      if (k == 1) set_mode(12, 3'h0);
      w16(`A_CAP_L, rnd16());
      get(`A_CAP_L, "cap low");
      get(`A_CAP_H, "cap high");
      get(`A_CTRL_B, "ctrl b");
    end
    for (i = 0; i < 14; i++) begin
      set_mode(modes[i], 3'h0);
      case (modes[i])
        1, 5: v = `TOP_8BIT;
        2, 6: v = `TOP_9BIT;
        3, 7: v = `TOP_10BIT;
        4, 9, 11, 15: v = 16'(ref_cmp[0]);
        default: v = 16'(ref_cap);
      endcase
      w16(`A_CNT_L, v);
      `CHK("top at ceiling", 1'b1, st.top)
      w16(`A_CNT_L, v - 16'h0001);
      `CHK("top below ceiling", 1'b0, st.top)
      `CHK("pwm a allowed", modes[i] != 9 && modes[i] != 11 && modes[i] != 15, pwm_a_allowed)
    end
    // Stopped PWM mode: new compare A waits in its buffer
    w16(`A_CMPA_L, ~v);
    w16(`A_CNT_L, v);
    `CHK("top double buffered", 1'b1, st.top)
    get(`A_CMPA_H, "cmp a buffer");
    set_mode(0, 3'h0);
    w16(`A_CNT_L, `CNT_MAX);
    `CHK("max", 2'b10, {st.max, st.bottom})
    w16(`A_CNT_L, `CNT_BOTTOM);
    `CHK("bottom", 2'b01, {st.max, st.bottom})
    put(`A_CTRL_C, 8'he0);
    seen = force_compare;
    @(posedge mclk);
    #1;
    seen |= force_compare;
    `CHK("force strobes", 3'b111, seen)
    get(`A_CTRL_C, "ctrl c");
    get(4'he, "unmapped");
    put(4'hf, 8'hff);
    w16(`A_CNT_L, 16'hfffc);
    `CHK("no overflow yet", 1'b0, overflow_flag)
    put(`A_CTRL_B, 8'h01);
    for (k = 0; k < 20 && overflow_flag !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    `CHK("overflow set", 1'b1, overflow_flag)
    put(`A_CTRL_B, 8'h00);
    u_cpu.access(`A_CNT_L, 1'b0, 8'h00, q);
    `CHK("wrapped count small", 1'b1, q < 8'h10)
    put(`A_FLAGS, 8'h01);
    `CHK("overflow cleared", 1'b0, overflow_flag)
    put(`A_CTRL_B, 8'h01);
    w16(`A_CNT_L, 16'h8000);
    put(`A_CTRL_B, 8'h00);
    u_cpu.access(`A_CNT_L, 1'b0, 8'h00, q);
    u_cpu.access(`A_CNT_H, 1'b0, 8'h00, q);
    `CHK("write beats count", 8'h80, q)
    `CHK("no overflow", 1'b0, overflow_flag)
    set_mode(5, 3'h0);
    w16(`A_CNT_L, 16'h00fd);
    set_mode(5, 3'h1);
    for (k = 0; k < 20 && overflow_flag !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    `CHK("fast wrap bottom", 1'b1, st.bottom)
    `CHK("fast overflow", 1'b1, overflow_flag)
    put(`A_CTRL_B, 8'h00);
    put(`A_FLAGS, 8'h01);
    set_mode(1, 3'h0);
    w16(`A_CNT_L, 16'h00fd);
    set_mode(1, 3'h1);
    for (k = 0; k < 20 && st.top !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    repeat (3) @(posedge mclk);
    put(`A_CTRL_B, 8'h00);
    // Up to TOP, then five ticks down before the stop lands
    ref_cnt = `TOP_8BIT - 16'h0005;
    get(`A_CNT_L, "phase count");
    get(`A_CNT_H, "phase count high");
    w16(`A_CNT_L, rnd16());
    @(posedge mclk);
    #1;
    cap_evt = 1'b1;
    @(posedge mclk);
    #1;
    cap_evt = 1'b0;
    ref_cap = ref_cnt;
    get(`A_CAP_L, "captured low");
    get(`A_CAP_H, "captured high");
    set_mode(0, 3'h7);
    pulses(3);
    set_mode(0, 3'h6);
    pulses(2);
    put(`A_CTRL_B, 8'h00);
    ref_cnt = (ref_cnt + 5) & 'hffff;
    get(`A_CNT_L, "pin count");
    get(`A_CNT_H, "pin count high");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
